/* rtl/cqsf_params.svh */
`ifndef CQSF_PARAMS_SVH
`define CQSF_PARAMS_SVH

// register indices; byte address is four times the index
`define CQSF_IDX_EDGE_RELOAD  8'hA3
`define CQSF_IDX_STATUS_FILT  8'hA4
`define CQSF_IDX_CC2_LOW      8'hA6
`define CQSF_IDX_CC2_HIGH     8'hA7
`define CQSF_IDX_MODE         8'hB8
`define CQSF_IDX_IRQ_MASK     8'hB9
`define CQSF_IDX_PCNT_LOW     8'hBA
`define CQSF_IDX_PCNT_HIGH    8'hBB

// status/filter register fields
`define CQSF_FILT_LSB         3
`define CQSF_FLAG_LSB         0
// mode register fields
`define CQSF_MODE_QEI_BIT     0
`define CQSF_MODE_CMP_BIT     1
`define CQSF_MODE_DIR_BIT     2

// edge selector codes
`define CQSF_EDGE_RISE        2'b00
`define CQSF_EDGE_FALL        2'b01
`define CQSF_EDGE_BOTH        2'b10
// reload source codes
`define CQSF_RLD_T3           2'b00
`define CQSF_RLD_CAP0         2'b01
`define CQSF_RLD_CAP1         2'b10
`define CQSF_RLD_CAP2         2'b11

// reset values and the full-scale word
`define CQSF_RST_BYTE         8'h00
`define CQSF_RST_WORD         16'h0000
`define CQSF_WORD_MAX         16'hFFFF

// filter: cycles an input must hold before it is accepted, and the width of its counter
`define CQSF_FILT_CYCLES      4
`define CQSF_FILT_CW          4

`endif

/* rtl/cqsf_pkg.sv */
`include "cqsf_params.svh"

package cqsf_pkg;

    typedef logic [`CQSF_FILT_CW-1:0] cqsf_fcnt_t;

    // all state of the capture / decoder block
    typedef struct packed {
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [2:0]       filt;
        cqsf_fcnt_t [2:0] fcnt;
        logic [2:0]       prev;
        logic [7:0]       edge_reload;
        logic [2:0]       filt_en;
        logic [2:0]       flags;
        logic [15:0]      cc2;
        logic             qei_mode;
        logic             cmp_mode;
        logic             dir;
        logic [2:0]       mask;
        logic [15:0]      tbase;
        logic [15:0]      pcnt;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
    } cqsf_state_t;

endpackage

/* rtl/cqsf_capture_qei.sv */
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "cqsf_params.svh"
module cqsf_capture_qei #(
    parameter int FILT_CYCLES = `CQSF_FILT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  cap_in,
    input  wire logic        t3_overflow,
    output logic             irq
);

    initial begin
        if (FILT_CYCLES < 1 || FILT_CYCLES >= (1 << `CQSF_FILT_CW)) begin
            $error("FILT_CYCLES out of range");
        end
    end

    localparam logic [`CQSF_FILT_CW-1:0] FLIM =
        (`CQSF_FILT_CW)'(FILT_CYCLES - 1);

    cqsf_pkg::cqsf_state_t st;
    cqsf_pkg::cqsf_state_t next_st;

    logic [2:0]  ev;
    logic        reload;
    logic        dir_chg;
    logic        wrap;
    logic [2:0]  clr;
    logic        wr_en;
    logic [7:0]  idx;
    logic [15:0] top;

    always_comb begin
        logic       step;
        logic       up;
        logic [1:0] sel;
        logic [7:0] rd;
        logic       hit;
        step    = 1'b0;
        up      = 1'b0;
        sel     = 2'b00;
        rd      = `CQSF_RST_BYTE;
        hit     = 1'b1;
        next_st = st;
        idx     = paddr[9:2];
        wr_en   = psel && penable && st.pready && pwrite && pstrb[0]
                  && !st.pslverr;

        // two-flop synchroniser, then optional stability filter
        next_st.sync1 = cap_in;
        next_st.sync2 = st.sync1;
        for (int i = 0; i < 3; i++) begin
            if (!st.filt_en[i] || st.sync2[i] == st.filt[i]) begin
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = '0;
            end else if (st.fcnt[i] == FLIM) begin
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = '0;
            end else begin
                next_st.fcnt[i] = st.fcnt[i] + 1'b1;
            end
        end
        next_st.prev = st.filt;

        // edge detection per channel; reserved code never fires
        for (int i = 0; i < 3; i++) begin
            sel = st.edge_reload[2*i+3 -: 2];
            unique case (sel)
                `CQSF_EDGE_RISE: ev[i] = st.filt[i] && !st.prev[i];
                `CQSF_EDGE_FALL: ev[i] = !st.filt[i] && st.prev[i];
                `CQSF_EDGE_BOTH: ev[i] = st.filt[i] != st.prev[i];
                default:         ev[i] = 1'b0;
            endcase
        end

        // reload source for the capture time base
        unique case (st.edge_reload[1:0])
            `CQSF_RLD_T3:   reload = t3_overflow;
            `CQSF_RLD_CAP0: reload = ev[0];
            `CQSF_RLD_CAP1: reload = ev[1];
            default:        reload = ev[2];
        endcase
        next_st.tbase = reload ? `CQSF_RST_WORD : st.tbase + 16'h0001;

        // quadrature decode on channels 0 (A) and 1 (B)
        step = (st.filt[0] != st.prev[0]) ^ (st.filt[1] != st.prev[1]);
        up   = st.prev[0] ^ st.filt[1];
        top  = st.cmp_mode ? st.cc2 : `CQSF_WORD_MAX;
        dir_chg = st.qei_mode && step && (up != st.dir);
        wrap    = 1'b0;
        if (st.qei_mode && step) begin
            next_st.dir = up;
            if (up) begin
                wrap         = st.pcnt == top;
                next_st.pcnt = wrap ? `CQSF_RST_WORD : st.pcnt + 16'h0001;
            end else begin
                wrap         = st.pcnt == `CQSF_RST_WORD;
                next_st.pcnt = wrap ? top : st.pcnt - 16'h0001;
            end
        end

        // register writes
        clr = 3'b000;
        if (wr_en) begin
            unique case (idx)
                `CQSF_IDX_EDGE_RELOAD: next_st.edge_reload = pwdata[7:0];
                `CQSF_IDX_STATUS_FILT: begin
                    next_st.filt_en = pwdata[`CQSF_FILT_LSB +: 3];
                    clr = pwdata[`CQSF_FLAG_LSB +: 3];
                end
                `CQSF_IDX_CC2_LOW:  next_st.cc2[7:0]  = pwdata[7:0];
                `CQSF_IDX_CC2_HIGH: next_st.cc2[15:8] = pwdata[7:0];
                `CQSF_IDX_MODE: begin
                    next_st.qei_mode = pwdata[`CQSF_MODE_QEI_BIT];
                    next_st.cmp_mode = pwdata[`CQSF_MODE_CMP_BIT];
                end
                `CQSF_IDX_IRQ_MASK: next_st.mask = pwdata[2:0];
                default: ;
            endcase
        end

        // capture 2 result; a capture beats a software write
        if (!st.qei_mode && ev[2]) begin
            next_st.cc2 = st.tbase;
        end

        // sticky flags: clear first, then events set (set wins)
        next_st.flags = st.flags & ~clr;
        if (ev[2]) begin
            next_st.flags[2] = 1'b1;
        end
        if (st.qei_mode) begin
            if (dir_chg) begin
                next_st.flags[1] = 1'b1;
            end
            if (wrap) begin
                next_st.flags[0] = 1'b1;
            end
        end else begin
            if (ev[1]) begin
                next_st.flags[1] = 1'b1;
            end
            if (ev[0]) begin
                next_st.flags[0] = 1'b1;
            end
        end
        next_st.irq = |(next_st.flags & next_st.mask);

        // apb: answer in the first access cycle, data prepared at setup
        next_st.pready  = psel && !penable;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            unique case (idx)
                `CQSF_IDX_EDGE_RELOAD: rd = st.edge_reload;
                `CQSF_IDX_STATUS_FILT: rd = {2'b00, st.filt_en, st.flags};
                `CQSF_IDX_CC2_LOW:     rd = st.cc2[7:0];
                `CQSF_IDX_CC2_HIGH:    rd = st.cc2[15:8];
                `CQSF_IDX_MODE:
                    rd = {5'b00000, st.dir, st.cmp_mode, st.qei_mode};
                `CQSF_IDX_IRQ_MASK:    rd = {5'b00000, st.mask};
                `CQSF_IDX_PCNT_LOW:    rd = st.pcnt[7:0];
                `CQSF_IDX_PCNT_HIGH:   rd = st.pcnt[15:8];
                default:               hit = 1'b0;
            endcase
            // unaligned or unmapped address answers with an error
            next_st.pslverr = !hit || (paddr[1:0] != 2'b00)
                              || (paddr[11:10] != 2'b00);
            next_st.prdata  = {24'h00_0000, rd};
        end
    end

    // counter snapshot state is lost on reset by design: software re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign irq     = st.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    filter_glitch_a: assert property (
        st.filt_en[2] && st.sync2[2] != st.filt[2] && st.fcnt[2] == '0
        ##1 st.sync2[2] == st.filt[2] |=> $stable(st.filt[2]))
        else $error("filtered input followed a one-cycle glitch");
    ch2_flag_a: assert property (
        ev[2] |=> st.flags[2])
        else $error("channel 2 event did not set its flag");
    ch1_flag_a: assert property (
        !st.qei_mode && ev[1] |=> st.flags[1] && !$past(st.qei_mode) ||
        st.flags[1])
        else $error("channel 1 event did not set its flag");
    ch0_flag_a: assert property (
        !st.qei_mode && ev[0] |=> st.flags[0])
        else $error("channel 0 event did not set its flag");
    dir_flag_a: assert property (
        dir_chg |=> st.flags[1] && st.dir == !$past(st.dir))
        else $error("direction change not flagged");
    dir_sticky_a: assert property (
        st.flags[1] && !(wr_en && idx == `CQSF_IDX_STATUS_FILT)
        |=> st.flags[1])
        else $error("direction flag cleared without software");
    free_wrap_a: assert property (
        st.qei_mode && !st.cmp_mode && wrap
        |=> st.flags[0] && (st.pcnt == 16'h0000 || st.pcnt == 16'hFFFF))
        else $error("free-counting wrap not flagged");
    // a wrap that leaves zero is a downward step, or an upward one when cc2 is zero
    cmp_wrap_a: assert property (
        st.qei_mode && st.cmp_mode && wrap && st.pcnt == 16'h0000
        |=> st.pcnt == $past(st.cc2))
        else $error("compare counter did not wrap to max count");
    cap2_value_a: assert property (
        !st.qei_mode && ev[2] |=> st.cc2 == $past(st.tbase))
        else $error("capture 2 result wrong");
    edge_reserved_a: assert property (
        st.edge_reload[7:6] == 2'b11 |-> !ev[2])
        else $error("reserved edge code produced an event");
    reload_t3_a: assert property (
        st.edge_reload[1:0] == `CQSF_RLD_T3 && t3_overflow
        |=> st.tbase == 16'h0000)
        else $error("timer 3 overflow did not reload the time base");
    set_wins_a: assert property (
        ev[2] && wr_en && idx == `CQSF_IDX_STATUS_FILT && pwdata[2]
        |=> st.flags[2])
        else $error("clear beat a same-cycle event");
    irq_level_a: assert property (
        |(st.flags & st.mask) |-> ##[0:1] irq)
        else $error("interrupt not raised for unmasked flag");

    // irq is registered from the same next values as flags and mask
    irq_off_a: assert property (
        !(|(st.flags & st.mask))
        |-> !irq)
        else $error("interrupt raised with no unmasked flag");

    // bus side: one ready pulse per setup, answered in the access cycle
    pready_pulse_a: assert property (
        psel && !penable
        |=> pready)
        else $error("no answer in the access cycle");

    pready_single_a: assert property (
        pready
        |=> !pready)
        else $error("ready held longer than one cycle");

    unaligned_err_a: assert property (
        psel && !penable && paddr[1:0] != 2'b00
        |=> pslverr)
        else $error("unaligned access not refused");

    high_addr_err_a: assert property (
        psel && !penable && paddr[11:10] != 2'b00
        |=> pslverr)
        else $error("out of range access not refused");

    rdata_upper_a: assert property (
        pready
        |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    // a write without its byte strobe must leave the registers alone
    strobe_gate_a: assert property (
        psel && penable && pready && pwrite && !pstrb[0]
        |=> $stable(st.mask) && $stable(st.edge_reload))
        else $error("write without strobe changed a register");

    mask_write_a: assert property (
        wr_en && idx == `CQSF_IDX_IRQ_MASK
        |=> st.mask == $past(pwdata[2:0]))
        else $error("mask write lost");

    edge_write_a: assert property (
        wr_en && idx == `CQSF_IDX_EDGE_RELOAD
        |=> st.edge_reload == $past(pwdata[7:0]))
        else $error("edge and reload select write lost");

    // filter enables and the bypass path
    filt_write_a: assert property (
        wr_en && idx == `CQSF_IDX_STATUS_FILT
        |=> st.filt_en == $past(pwdata[5:3]))
        else $error("filter enable write lost");

    filt_bypass_a: assert property (
        !st.filt_en[0]
        |=> st.filt[0] == $past(st.sync2[0]))
        else $error("unfiltered input did not pass straight through");

    // time base: counts every cycle, cleared by the chosen source
    reload_cap2_a: assert property (
        st.edge_reload[1:0] == `CQSF_RLD_CAP2 && ev[2]
        |=> st.tbase == 16'h0000)
        else $error("capture 2 did not reload the time base");

    tbase_run_a: assert property (
        !reload
        |=> st.tbase == $past(st.tbase) + 16'h0001)
        else $error("time base did not count");

    // quadrature state stays frozen outside quadrature mode
    pcnt_idle_a: assert property (
        !st.qei_mode
        |=> $stable(st.pcnt))
        else $error("pulse counter moved in capture mode");

    dir_idle_a: assert property (
        !st.qei_mode
        |=> $stable(st.dir))
        else $error("direction moved in capture mode");

    cc2_hold_a: assert property (
        st.qei_mode && !wr_en
        |=> $stable(st.cc2))
        else $error("max count changed without a write");

    // channel 1 edges must not reach bit 1 while decoding
    qei_quiet_a: assert property (
        st.qei_mode && !dir_chg && !st.flags[1]
        |=> !st.flags[1])
        else $error("bit 1 set without a direction change");

    ch2_quad_a: assert property (
        st.qei_mode && ev[2]
        |=> st.flags[2])
        else $error("channel 2 flag lost in quadrature mode");

endmodule

/* verif/cqsf_encoder_model.sv */
`timescale 1ns/1ps
// far side: three capture pins, pins 0 and 1 double as encoder A and B
module cqsf_encoder_model (
    input  wire logic       pclk,
    output logic      [2:0] cap_in
);
    logic [1:0] phase;
    // forward order of {A,B}; one line changes per step
    logic [1:0] gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

    initial begin
        cap_in = 3'b000;
        phase  = 2'd0;
    end

    // level change, then room for sync and edge detect
    task automatic drive(input int ch, input logic val);
        @(posedge pclk);
        cap_in[ch] <= val;
        repeat (8) @(posedge pclk);
    endtask

    // one-cycle spike, shorter than any filter window of two or more cycles
    task automatic glitch(input int ch);
        @(posedge pclk);
        cap_in[ch] <= 1'b1;
        @(posedge pclk);
        cap_in[ch] <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // single-bit encoder step, forward or back
    task automatic step(input logic up);
        phase = up ? phase + 2'd1 : phase - 2'd1;
        @(posedge pclk);
        cap_in[1:0] <= {gray[phase][0], gray[phase][1]};
        repeat (8) @(posedge pclk);
    endtask
endmodule

/* verif/capture_qei_status_flags_test.sv */
`timescale 1ns/1ps
`include "cqsf_params.svh"
module capture_qei_status_flags_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        t3_overflow, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0]  pstrb;
    logic [2:0]  cap_in;
    int          num_errors, compares, cycles;

    cqsf_capture_qei u_cqsf_capture_qei (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cap_in(cap_in), .t3_overflow(t3_overflow), .irq(irq));
    cqsf_encoder_model u_cqsf_encoder_model (.pclk(pclk), .cap_in(cap_in));

    always #5 pclk = ~pclk;

    // hang guard, far above the several hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0000_00, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d, v, err);
    endtask

    task automatic rd8(input logic [7:0] idx, output logic [31:0] d);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, d, err);
    endtask

    // read flags and irq, then clear what was expected
    task automatic chk_flags(input logic [2:0] e);
        rd8(`CQSF_IDX_STATUS_FILT, v);
        chk("flags", {29'h0, e}, {29'h0, v[2:0]});
        chk("irq", {31'h0, |e}, {31'h0, irq});
        wr8(`CQSF_IDX_STATUS_FILT, {5'h00, e});
    endtask

    task automatic test_regs();
        rd8(`CQSF_IDX_STATUS_FILT, v);
        chk("status reset", 32'h0000_0000, v);
        wr8(`CQSF_IDX_CC2_LOW, 8'h5A);
        wr8(`CQSF_IDX_CC2_HIGH, 8'hA5);
        rd8(`CQSF_IDX_CC2_LOW, v);
        chk("cc2 low", 32'h0000_005A, v);
        rd8(`CQSF_IDX_CC2_HIGH, v);
        chk("cc2 high", 32'h0000_00A5, v);
        apb(1'b0, 12'h294, 8'h00, v, err);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, v);
    endtask

    // masked event must not interrupt; unmask raises, clear drops
    task automatic test_irq();
        wr8(`CQSF_IDX_IRQ_MASK, 8'h00);
        wr8(`CQSF_IDX_EDGE_RELOAD, 8'h00);
        u_cqsf_encoder_model.drive(2, 1'b1);
        chk("masked irq", 32'h0000_0000, {31'h0, irq});
        wr8(`CQSF_IDX_IRQ_MASK, 8'h04);
        repeat (2) @(posedge pclk);
        chk("unmasked irq", 32'h0000_0001, {31'h0, irq});
        wr8(`CQSF_IDX_STATUS_FILT, 8'h04);
        repeat (2) @(posedge pclk);
        chk("cleared irq", 32'h0000_0000, {31'h0, irq});
        u_cqsf_encoder_model.drive(2, 1'b0);
        wr8(`CQSF_IDX_IRQ_MASK, 8'h07);
    endtask

    // every edge code on every channel, rising then falling
    task automatic test_capture();
        logic [1:0] c;
        for (int ch = 0; ch < 3; ch++) begin
            for (int k = 0; k < 4; k++) begin
                c = k[1:0];
                wr8(`CQSF_IDX_EDGE_RELOAD, 8'(c) << (2 + 2 * ch));
                u_cqsf_encoder_model.drive(ch, 1'b1);
                chk_flags((c == 2'b00 || c == 2'b10) ? 3'(1 << ch) : 3'b000);
                u_cqsf_encoder_model.drive(ch, 1'b0);
                chk_flags((c == 2'b01 || c == 2'b10) ? 3'(1 << ch) : 3'b000);
            end
        end
    endtask

    // spike swallowed with the filter on, flagged with it off
    task automatic test_filter();
        wr8(`CQSF_IDX_EDGE_RELOAD, 8'h00);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h38);
        u_cqsf_encoder_model.glitch(0);
        rd8(`CQSF_IDX_STATUS_FILT, v);
        chk("filtered", 32'h0000_0038, v);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h30);
        u_cqsf_encoder_model.glitch(0);
        rd8(`CQSF_IDX_STATUS_FILT, v);
        chk("unfiltered", 32'h0000_0031, v);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h01);
    endtask

    // t3 pulse clears the time base; capture 2 stores it four cycles on
    task automatic test_reload();
        wr8(`CQSF_IDX_EDGE_RELOAD, 8'h00);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h07);
        @(posedge pclk);
        t3_overflow <= 1'b1;
        @(posedge pclk);
        t3_overflow <= 1'b0;
        u_cqsf_encoder_model.drive(2, 1'b1);
        rd8(`CQSF_IDX_CC2_LOW, v);
        chk("reload cc2 low", 32'h0000_0004, v);
        rd8(`CQSF_IDX_CC2_HIGH, v);
        chk("reload cc2 high", 32'h0000_0000, v);
        chk_flags(3'b100);
        u_cqsf_encoder_model.drive(2, 1'b0);
        pstrb <= 4'h0;
        wr8(`CQSF_IDX_IRQ_MASK, 8'h00);
        pstrb <= 4'hF;
        rd8(`CQSF_IDX_IRQ_MASK, v);
        chk("strobe off mask", 32'h0000_0007, v);
    endtask

    // mid-run reset returns every register to zero
    task automatic test_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd8(`CQSF_IDX_STATUS_FILT, v);
        chk("status after reset", 32'h0000_0000, v);
        rd8(`CQSF_IDX_IRQ_MASK, v);
        chk("mask after reset", 32'h0000_0000, v);
        rd8(`CQSF_IDX_MODE, v);
        chk("mode after reset", 32'h0000_0000, v);
        chk("irq after reset", 32'h0000_0000, {31'h0, irq});
    endtask

    task automatic test_quad();
        wr8(`CQSF_IDX_CC2_LOW, 8'h03);
        wr8(`CQSF_IDX_CC2_HIGH, 8'h00);
        wr8(`CQSF_IDX_MODE, 8'h03);
        repeat (3) u_cqsf_encoder_model.step(1'b1);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h07);
        rd8(`CQSF_IDX_PCNT_LOW, v);
        chk("count", 32'h0000_0003, v);
        u_cqsf_encoder_model.step(1'b1);
        chk_flags(3'b001);
        u_cqsf_encoder_model.step(1'b0);
        repeat (20) @(posedge pclk);
        chk_flags(3'b011);
        wr8(`CQSF_IDX_MODE, 8'h01);
        repeat (3) u_cqsf_encoder_model.step(1'b0);
        wr8(`CQSF_IDX_STATUS_FILT, 8'h07);
        u_cqsf_encoder_model.step(1'b0);
        chk_flags(3'b001);
        rd8(`CQSF_IDX_PCNT_HIGH, v);
        chk("count high", 32'h0000_00FF, v);
        u_cqsf_encoder_model.step(1'b1);
        chk_flags(3'b011);
    endtask

    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0000_0000;
        pstrb       = 4'hF;
        t3_overflow = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_irq();
        test_capture();
        test_filter();
        test_reload();
        test_quad();
        test_reset();
        conclude();
    end
endmodule
